// file: core/sgcl_pkg.sv
// Shared constants for the status, gain trim and AC amplitude register slice
`default_nettype none
package sgcl_pkg;

	// ----------------------------------------------------------------
	// Register addresses (command address field, bits [31:24] of a word)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_OPERATING_STATE   = 8'h1f;
	localparam logic [7:0] ADDR_TRIM_LEFT_ARM     = 8'h21;
	localparam logic [7:0] ADDR_TRIM_LEFT_LEG     = 8'h22;
	localparam logic [7:0] ADDR_TRIM_RIGHT_ARM    = 8'h23;
	localparam logic [7:0] ADDR_AMP_LEFT_ARM      = 8'h31;
	localparam logic [7:0] ADDR_AMP_LEFT_LEG      = 8'h32;
	localparam logic [7:0] ADDR_AMP_RIGHT_ARM     = 8'h33;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int         ADDR_LSB               = 24;
	localparam int         DATA_W                 = 24;
	localparam int         FAULT_BIT              = 3;
	localparam int         CFG_PENDING_BIT        = 2;
	localparam int         LOCK_LOST_BIT          = 1;
	localparam int         LOCKED_BIT             = 0;
	localparam int         TRIM_SRC_BIT           = 23;
	localparam int         TRIM_W                 = 12;
	localparam int         AMP_W                  = 16;
	localparam int         TRIM_SHIFT             = 17;
	localparam int         CHAN_COUNT             = 3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [23:0] RESET_REG             = 24'h000000;
	localparam logic [11:0] RESET_TRIM            = 12'h000;
	localparam logic [15:0] RESET_AMP             = 16'h0000;

	// ----------------------------------------------------------------
	// Timing: amplitude refresh rate
	// ----------------------------------------------------------------
	localparam int         CLK_HZ                 = 50_000_000;
	localparam int         AMP_UPDATE_HZ          = 8;
	localparam int         AMP_UPDATE_CYCLES      = CLK_HZ / AMP_UPDATE_HZ;
	localparam int         LPF_SHIFT              = 7;

endpackage : sgcl_pkg
`default_nettype wire

// file: core/sgcl_amp_avg.sv
// Rectify and low-pass one band-pass channel into an unsigned amplitude code
`default_nettype none
module sgcl_amp_avg #(
	parameter int DW    = sgcl_pkg::AMP_W,
	parameter int SHIFT = sgcl_pkg::LPF_SHIFT
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 srst_i,
	// Band-pass samples
	input  wire logic                 sample_valid_i,
	input  wire logic signed [DW-1:0] sample_i,
	// Control
	input  wire logic                 enable_i,
	input  wire logic                 update_i,
	// Result
	output logic         [DW-1:0]     amplitude_o
);
	import sgcl_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DW+SHIFT-1:0] acc;        // Filter state with fraction bits
		logic [DW-1:0]       amplitude;  // Published code
	} sgcl_avg_state_t;

	sgcl_avg_state_t state;              // Registered state
	sgcl_avg_state_t next_state;         // Next state

	logic [DW:0]         mag;            // Magnitude, one bit wider
	logic [DW-1:0]       rect;           // Doubled magnitude, saturated
	logic [DW+SHIFT:0]   sum;            // Filter update with carry room

	// ----------------------------------------------------------------
	// Filter update
	// ----------------------------------------------------------------
	// First-order low pass: acc += x - acc/2^SHIFT; output is acc/2^SHIFT
	always_comb begin
		next_state = state;
		mag        = sample_i[DW-1] ? (DW+1)'(-sample_i) : {1'b0, sample_i};
		// A full-scale signed swing maps onto the full unsigned range
		rect       = mag[DW-1] | mag[DW] ? {DW{1'b1}} : {mag[DW-2:0], 1'b0};
		sum        = {1'b0, state.acc} + {{(SHIFT+1){1'b0}}, rect} -
		             {{(SHIFT+1){1'b0}}, state.acc[DW+SHIFT-1:SHIFT]};
		if (!enable_i) begin
			// Filter held clear so a fresh selection starts from zero
			next_state.acc = '0;
		end else if (sample_valid_i) begin
			next_state.acc = sum[DW+SHIFT-1:0];
		end
		if (update_i && enable_i) begin
			// Published only on the slow refresh tick
			next_state.amplitude = state.acc[DW+SHIFT-1:SHIFT];
		end
	end

	// Register the state
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			// Filter and published code both start from zero
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign amplitude_o = state.amplitude;

endmodule : sgcl_amp_avg
`default_nettype wire

// file: core/sgcl_regs.sv
// Operating-state, gain trim and AC lead-off amplitude register slice
`default_nettype none
module sgcl_regs #(
	parameter int          UPDATE_CYCLES  = sgcl_pkg::AMP_UPDATE_CYCLES,
	parameter int          SAMPLE_W       = 24,
	parameter logic [11:0] FACTORY_TRIM_0 = 12'h000,
	parameter logic [11:0] FACTORY_TRIM_1 = 12'h000,
	parameter logic [11:0] FACTORY_TRIM_2 = 12'h000
) (
	// Clock and reset
	input  wire logic                                  clk_i,
	input  wire logic                                  srst_i,
	// Register command from the serial port
	input  wire logic                                  cmd_valid_i,
	input  wire logic                                  cmd_write_i,
	input  wire logic [7:0]                            cmd_addr_i,
	input  wire logic [sgcl_pkg::DATA_W-1:0]           cmd_wdata_i,
	// Register read answer
	output logic                                       rd_valid_o,
	output logic [31:0]                                rd_data_o,
	// Device status inputs
	input  wire logic                                  internal_error_i,
	input  wire logic                                  config_loaded_i,
	input  wire logic                                  pll_locked_i,
	input  wire logic                                  power_enable_bit_i,
	input  wire logic [1:0]                            gain_setting_i,
	input  wire logic                                  ac_leadoff_sel_i,
	// Channel data to be trimmed (index 0 left arm, 1 left leg, 2 right arm)
	input  wire logic                                  chan_valid_i,
	input  wire logic [sgcl_pkg::CHAN_COUNT*SAMPLE_W-1:0] chan_data_i,
	output logic                                       cal_valid_o,
	output logic [sgcl_pkg::CHAN_COUNT*SAMPLE_W-1:0]   cal_data_o,
	// Band-pass outputs for AC lead-off measurement
	input  wire logic                                  bp_valid_i,
	input  wire logic [sgcl_pkg::CHAN_COUNT*sgcl_pkg::AMP_W-1:0] bp_data_i
);
	import sgcl_pkg::*;

	// ----------------------------------------------------------------
	// Local types
	// ----------------------------------------------------------------
	localparam int DIV_W = $clog2(UPDATE_CYCLES + 1);

	typedef struct packed {
		logic                              fault;       // Sticky internal error
		logic                              cfg_pending; // Configuration not loaded
		logic                              lock_lost;   // Sticky PLL lock lost
		logic                              lock_armed;  // PLL was enabled and locked
		logic [CHAN_COUNT-1:0]             trim_src;    // 1 selects user trim
		logic [CHAN_COUNT-1:0][TRIM_W-1:0] user_trim;   // User-written trims
		logic [DIV_W-1:0]                  div_cnt;     // Refresh divider
		logic                              tick;        // Refresh enable pulse
		logic                              rd_valid;    // Read answer strobe
		logic [31:0]                       rd_data;     // Read answer word
		logic                              cal_valid;   // Trimmed data strobe
		logic [CHAN_COUNT*SAMPLE_W-1:0]    cal_data;    // Trimmed data
	} sgcl_state_t;

	sgcl_state_t state;                                 // Registered state
	sgcl_state_t next_state;                            // Next state

	logic [CHAN_COUNT-1:0][AMP_W-1:0]  amplitude;       // Per-electrode averages
	logic [CHAN_COUNT-1:0][TRIM_W-1:0] trim_eff;        // Trims in force
	logic                              rd_req;          // Read command this cycle
	logic                              wr_req;          // Write command this cycle

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Factory trim per gain; gain 3 has none, so it reads and acts as zero
	function automatic logic [TRIM_W-1:0] factory_trim(input logic [1:0] gain);
		logic [TRIM_W-1:0] t;
		unique case (gain)
			2'd0:    t = FACTORY_TRIM_0;
			2'd1:    t = FACTORY_TRIM_1;
			2'd2:    t = FACTORY_TRIM_2;
			default: t = RESET_TRIM;
		endcase
		return t;
	endfunction : factory_trim

	// Map trim register address to channel index, or 3 for no match
	function automatic logic [1:0] trim_index(input logic [7:0] addr);
		logic [1:0] idx;
		unique case (addr)
			ADDR_TRIM_LEFT_ARM:  idx = 2'd0;
			ADDR_TRIM_LEFT_LEG:  idx = 2'd1;
			ADDR_TRIM_RIGHT_ARM: idx = 2'd2;
			default:             idx = 2'd3;
		endcase
		return idx;
	endfunction : trim_index

	// Map amplitude register address to channel index, or 3 for no match
	function automatic logic [1:0] amp_index(input logic [7:0] addr);
		logic [1:0] idx;
		unique case (addr)
			ADDR_AMP_LEFT_ARM:  idx = 2'd0;
			ADDR_AMP_LEFT_LEG:  idx = 2'd1;
			ADDR_AMP_RIGHT_ARM: idx = 2'd2;
			default:            idx = 2'd3;
		endcase
		return idx;
	endfunction : amp_index

	// data * (1 + trim * 2^-17), truncated toward minus infinity
	function automatic logic [SAMPLE_W-1:0] apply_trim(
		input logic [SAMPLE_W-1:0] data,
		input logic [TRIM_W-1:0]   trim
	);
		logic signed [SAMPLE_W+TRIM_W-1:0] prod;
		logic signed [SAMPLE_W+TRIM_W-1:0] adj;
		logic signed [SAMPLE_W:0]          sum;
		logic signed [SAMPLE_W:0]          hi;
		logic signed [SAMPLE_W:0]          lo;
		prod = $signed(data) * $signed(trim);
		adj  = prod >>> TRIM_SHIFT;
		sum  = (SAMPLE_W+1)'($signed(data)) + adj[SAMPLE_W:0];
		hi   = (SAMPLE_W+1)'({1'b0, {(SAMPLE_W-1){1'b1}}});
		lo   = -hi - (SAMPLE_W+1)'(1);
		// Saturate: a trim near +2047 can push full scale past the range
		if (sum > hi) begin
			sum = hi;
		end else if (sum < lo) begin
			sum = lo;
		end
		return sum[SAMPLE_W-1:0];
	endfunction : apply_trim

	// ----------------------------------------------------------------
	// Amplitude averagers, one per electrode
	// ----------------------------------------------------------------
	for (genvar c = 0; c < CHAN_COUNT; c++) begin : g_amp
		sgcl_amp_avg #(
			.DW    (AMP_W),
			.SHIFT (LPF_SHIFT)
		) u_avg (
			.clk_i          (clk_i),
			.srst_i         (srst_i),
			.sample_valid_i (bp_valid_i),
			.sample_i       (bp_data_i[c*AMP_W +: AMP_W]),
			.enable_i       (ac_leadoff_sel_i),
			.update_i       (state.tick),
			.amplitude_o    (amplitude[c])
		);
	end

	// ----------------------------------------------------------------
	// Trims in force
	// ----------------------------------------------------------------
	// Source bit picks user or factory trim for each channel
	always_comb begin
		for (int c = 0; c < CHAN_COUNT; c++) begin
			trim_eff[c] = state.trim_src[c] ? state.user_trim[c] :
			              factory_trim(gain_setting_i);
		end
	end

	// Command qualifiers
	assign rd_req = cmd_valid_i && !cmd_write_i;
	assign wr_req = cmd_valid_i && cmd_write_i;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0] ti;
		logic [1:0] ai;
		logic       clr_lost;
		logic       set_lost;
		next_state = state;
		ti         = trim_index(cmd_addr_i);
		ai         = amp_index(cmd_addr_i);

		// Status flags
		// Internal error is sticky until reset so a brief fault is not missed
		if (internal_error_i) begin
			next_state.fault = 1'b1;
		end
		// Pending stays high from reset until configuration lands
		if (config_loaded_i) begin
			next_state.cfg_pending = 1'b0;
		end
		// Arm only once the PLL is powered and has locked
		if (!power_enable_bit_i) begin
			next_state.lock_armed = 1'b0;
		end else if (pll_locked_i) begin
			next_state.lock_armed = 1'b1;
		end
		set_lost = state.lock_armed && power_enable_bit_i && !pll_locked_i;
		clr_lost = (rd_req && cmd_addr_i == ADDR_OPERATING_STATE) ||
		           !power_enable_bit_i;
		// A loss in the same cycle as the clearing read is kept
		if (set_lost) begin
			next_state.lock_lost = 1'b1;
		end else if (clr_lost) begin
			next_state.lock_lost = 1'b0;
		end

		// Refresh divider for the amplitude registers
		if (state.div_cnt == DIV_W'(UPDATE_CYCLES - 1)) begin
			next_state.div_cnt = '0;
			next_state.tick    = 1'b1;
		end else begin
			next_state.div_cnt = state.div_cnt + DIV_W'(1);
			next_state.tick    = 1'b0;
		end

		// Register writes: only trim registers are writable
		if (wr_req && ti != 2'd3) begin
			next_state.trim_src[ti]  = cmd_wdata_i[TRIM_SRC_BIT];
			// Reserved bits [22:12] are dropped, never stored
			next_state.user_trim[ti] = cmd_wdata_i[TRIM_W-1:0];
		end

		// Register reads: answer echoes the address in the top byte
		next_state.rd_valid = rd_req;
		next_state.rd_data  = {cmd_addr_i, RESET_REG};
		if (rd_req) begin
			if (cmd_addr_i == ADDR_OPERATING_STATE) begin
				// Returned only on this explicit read, never in frames
				next_state.rd_data[FAULT_BIT]       = state.fault;
				next_state.rd_data[CFG_PENDING_BIT] = state.cfg_pending;
				next_state.rd_data[LOCK_LOST_BIT]   = state.lock_lost;
				next_state.rd_data[LOCKED_BIT]      = pll_locked_i;
			end else if (ti != 2'd3) begin
				next_state.rd_data[TRIM_SRC_BIT]    = state.trim_src[ti];
				next_state.rd_data[TRIM_W-1:0]      = trim_eff[ti];
			end else if (ai != 2'd3) begin
				next_state.rd_data[AMP_W-1:0]       = amplitude[ai];
			end
			// Unmapped addresses answer with a zero data field
		end

		// Channel gain trim path, one cycle of latency
		next_state.cal_valid = chan_valid_i;
		if (chan_valid_i) begin
			for (int c = 0; c < CHAN_COUNT; c++) begin
				next_state.cal_data[c*SAMPLE_W +: SAMPLE_W] =
					apply_trim(chan_data_i[c*SAMPLE_W +: SAMPLE_W], trim_eff[c]);
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state             <= '0;
			state.cfg_pending <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign rd_valid_o  = state.rd_valid;
	assign rd_data_o   = state.rd_data;
	assign cal_valid_o = state.cal_valid;
	assign cal_data_o  = state.cal_data;

endmodule : sgcl_regs
`default_nettype wire

// file: test/sgcl_regs_chk.sv
// Concurrent checks on the ports of the register slice
`default_nettype none
module sgcl_regs_chk (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        srst_i,
	// Command and answer
	input wire logic        cmd_valid_i,
	input wire logic        cmd_write_i,
	input wire logic [7:0]  cmd_addr_i,
	input wire logic        rd_valid_o,
	input wire logic [31:0] rd_data_o,
	// Status and trim path
	input wire logic        internal_error_i,
	input wire logic        config_loaded_i,
	input wire logic        pll_locked_i,
	input wire logic        power_enable_bit_i,
	input wire logic        chan_valid_i,
	input wire logic        cal_valid_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// ----
	// Helper state
	// ----
	logic seen_err;  // Error seen since reset
	logic seen_cfg;  // Config load seen since reset
	// Both flags in the slice are sticky, so only "ever seen" matters
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			seen_err <= 1'b0;
			seen_cfg <= 1'b0;
		end else begin
			seen_err <= seen_err | internal_error_i;
			seen_cfg <= seen_cfg | config_loaded_i;
		end
	end
	// ----
	// Sequences and assertions
	// ----
	sequence s_read_cmd;
		cmd_valid_i && !cmd_write_i;
	endsequence
	sequence s_state_ans;
		rd_valid_o && rd_data_o[31:24] == 8'h1f;
	endsequence
	a_read_answer: assert property (s_read_cmd |=> rd_valid_o) else $error("read without answer");
	a_answer_cause: assert property (rd_valid_o |-> $past(cmd_valid_i && !cmd_write_i))
		else $error("answer without read");
	a_addr_echo: assert property (rd_valid_o |-> rd_data_o[31:24] == $past(cmd_addr_i))
		else $error("answer address wrong");
	a_state_resv: assert property (s_state_ans |-> rd_data_o[23:4] == 20'h0) else $error("status high bits set");
	a_fault_flag: assert property (s_state_ans |-> rd_data_o[3] == $past(seen_err)) else $error("fault bit wrong");
	a_cfg_flag: assert property (s_state_ans |-> rd_data_o[2] == !$past(seen_cfg)) else $error("pending bit wrong");
	a_live_lock: assert property (s_state_ans |-> rd_data_o[0] == $past(pll_locked_i)) else $error("lock bit wrong");
	a_power_clear: assert property (s_state_ans ##0 !$past(power_enable_bit_i) ##0 !$past(power_enable_bit_i, 2)
		|-> !rd_data_o[1]) else $error("lost bit kept while powered off");
	a_trim_resv: assert property (rd_valid_o && rd_data_o[31:28] == 4'h2 |-> rd_data_o[22:12] == 11'h0)
		else $error("trim reserved bits set");
	a_amp_resv: assert property (rd_valid_o && rd_data_o[31:28] == 4'h3 |-> rd_data_o[23:16] == 8'h0)
		else $error("amplitude reserved bits set");
	a_cal_strobe: assert property (chan_valid_i |=> cal_valid_o) else $error("trimmed sample missing");
	a_cal_cause: assert property (cal_valid_o |-> $past(chan_valid_i)) else $error("spurious trimmed sample");
endmodule : sgcl_regs_chk
bind sgcl_regs sgcl_regs_chk i_chk (.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
	.cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
	.internal_error_i(internal_error_i), .config_loaded_i(config_loaded_i), .pll_locked_i(pll_locked_i),
	.power_enable_bit_i(power_enable_bit_i), .chan_valid_i(chan_valid_i), .cal_valid_o(cal_valid_o));
`default_nettype wire

// file: test/sgcl_host.sv
// Host model issuing register commands to the slice
`default_nettype none
module sgcl_host (
	// Clock
	input  wire logic        clk_i,
	// Command towards the slice
	output var  logic        cmd_valid_o,
	output var  logic        cmd_write_o,
	output var  logic [7:0]  cmd_addr_o,
	output var  logic [23:0] cmd_wdata_o,
	// Read answer
	input  wire logic        rd_valid_i,
	input  wire logic [31:0] rd_data_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_addr_o  = 8'h00;
		cmd_wdata_o = 24'h0;
	end
	// One command word; a read waits a bounded time for its answer
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [23:0] d, output logic [31:0] q);
		int i;
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_write_o <= wr;
		cmd_addr_o  <= a;
		cmd_wdata_o <= d;
		@(posedge clk_i);
		// Idle fields flip so a stale value is never mistaken for a held one
		cmd_valid_o <= 1'b0;
		cmd_write_o <= ~wr;
		cmd_addr_o  <= ~a;
		cmd_wdata_o <= ~d;
		q = 'x;
		// Status comes back only through an explicit read
		if (!wr) begin
			for (i = 0; i < 4; i++) begin
				@(negedge clk_i);
				if (rd_valid_i === 1'b1) begin
					q = rd_data_i;
					break;
				end
			end
		end
	endtask : xfer
endmodule : sgcl_host
`default_nettype wire

// file: test/sgcl_regs_bench.sv
// Self-checking bench for the register slice
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected at %0t: %h vs %h", $time, g, e); end end
module sgcl_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Stimulus and observed signals
	// ----
	logic clk = 1'b0, srst, cmd_valid, cmd_write, rd_valid, internal_error, config_loaded, pll_locked;
	logic power_en, ac_sel, chan_valid, cal_valid, bp_valid;
	logic [1:0]  gain;
	logic [7:0]  cmd_addr, a;
	logic [23:0] cmd_wdata, d[3];
	logic [31:0] rd_data;
	logic [71:0] chan_data, cal_data;
	logic [47:0] bp_data;
	logic [11:0] t[3];
	logic [15:0] s[3];
	int n_mismatch = 0, n_checks = 0, cyc = 0, i, k;
	// Short refresh period keeps the amplitude test brief
	sgcl_regs #(.UPDATE_CYCLES(16), .FACTORY_TRIM_0(12'h123), .FACTORY_TRIM_1(12'h7ff), .FACTORY_TRIM_2(12'h800))
	i_sgcl_regs (.clk_i(clk), .srst_i(srst), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
		.cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
		.internal_error_i(internal_error), .config_loaded_i(config_loaded), .pll_locked_i(pll_locked),
		.power_enable_bit_i(power_en), .gain_setting_i(gain), .ac_leadoff_sel_i(ac_sel),
		.chan_valid_i(chan_valid), .chan_data_i(chan_data), .cal_valid_o(cal_valid), .cal_data_o(cal_data),
		.bp_valid_i(bp_valid), .bp_data_i(bp_data));
	sgcl_host i_sgcl_host (.clk_i(clk), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
		.cmd_addr_o(cmd_addr), .cmd_wdata_o(cmd_wdata), .rd_valid_i(rd_valid), .rd_data_i(rd_data));
	always #10 clk = ~clk;
	// ----
	// Expectations
	// ----
	// Factory trim per gain; gain 3 has none
	function automatic logic [11:0] fact(input int g);
		return (g == 0) ? 12'h123 : (g == 1) ? 12'h7ff : (g == 2) ? 12'h800 : 12'h000;
	endfunction : fact
	// Data times one plus trim over 2^17, saturated to 24 bits
	function automatic logic [23:0] exp_cal(input logic [23:0] x, input logic [11:0] tr);
		logic signed [47:0] p;
		p = $signed(x) * $signed(tr);
		p = (p >>> 17) + $signed(x);
		if (p > 48'sh7fffff) return 24'h7fffff;
		if (p < -48'sh800000) return 24'h800000;
		return p[23:0];
	endfunction : exp_cal
	// Settled rectified level, clipped at full scale
	function automatic logic [15:0] amp_exp(input logic [15:0] v);
		logic [17:0] m;
		m = v[15] ? 18'h10000 - 18'(v) : 18'(v);
		m = m << 1;
		return (m > 18'hffff) ? 16'hffff : m[15:0];
	endfunction : amp_exp
	// ----
	// Bus tasks and closing
	// ----
	task automatic chk_rd(input logic [7:0] ad, input logic [31:0] e);
		logic [31:0] q;
		i_sgcl_host.xfer(1'b0, ad, 24'h0, q);
		`CHK(q, e)
	endtask : chk_rd
	task automatic wr(input logic [7:0] ad, input logic [23:0] v);
		logic [31:0] q;
		i_sgcl_host.xfer(1'b1, ad, v, q);
	endtask : wr
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_cyc
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	// Hang guard, well above the expected run of some 4200 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	// ----
	// Main sequence
	// ----
	initial begin
		{srst, internal_error, config_loaded, pll_locked, power_en, ac_sel, chan_valid, bp_valid} = 8'h80;
		gain = 2'd0;
		chan_data = '0;
		bp_data = '0;
		void'($urandom(91363));
		wait_cyc(3);
		srst <= 1'b0;
		chk_rd(8'h1f, {8'h1f, 20'h0, 4'b0100});
		for (k = 0; k < 3; k++) begin
			chk_rd(8'h21 + 8'(k), {8'h21 + 8'(k), 12'h0, fact(0)});
			chk_rd(8'h31 + 8'(k), {8'h31 + 8'(k), 24'h0});
		end
		// Load config, power up and lock
		@(posedge clk);
		{config_loaded, pll_locked, power_en} <= 3'b111;
		@(posedge clk);
		config_loaded <= 1'b0;
		wait_cyc(2);
		chk_rd(8'h1f, {8'h1f, 20'h0, 4'b0001});
		// Lose lock and regain it: the loss stays until read
		@(posedge clk);
		pll_locked <= 1'b0;
		wait_cyc(3);
		pll_locked <= 1'b1;
		wait_cyc(2);
		chk_rd(8'h1f, {8'h1f, 20'h0, 4'b0011});
		chk_rd(8'h1f, {8'h1f, 20'h0, 4'b0001});
		// Lose lock again, then power off clears it
		@(posedge clk);
		pll_locked <= 1'b0;
		wait_cyc(3);
		{pll_locked, power_en} <= 2'b10;
		wait_cyc(3);
		chk_rd(8'h1f, {8'h1f, 20'h0, 4'b0001});
		@(posedge clk);
		internal_error <= 1'b1;
		@(posedge clk);
		internal_error <= 1'b0;
		wait_cyc(2);
		repeat (2) chk_rd(8'h1f, {8'h1f, 20'h0, 4'b1001});
		// Read-only and unmapped writes are dropped
		wr(8'h1f, 24'hffffff);
		wr(8'h40, 24'h123456);
		chk_rd(8'h40, {8'h40, 24'h0});
		chk_rd(8'h1f, {8'h1f, 20'h0, 4'b1001});
		// User trims, reserved bits written as ones
		t[0] = 12'h7ff;
		t[1] = 12'h800;
		t[2] = 12'($urandom);
		for (k = 0; k < 3; k++) begin
			a = 8'h21 + 8'(k);
			wr(a, {1'b1, 11'h7ff, t[k]});
			chk_rd(a, {a, 1'b1, 11'h0, t[k]});
		end
		@(posedge clk);
		gain <= 2'($urandom);
		// First two rounds hit full scale in both directions
		for (i = 0; i < 6; i++) begin
			for (k = 0; k < 3; k++) d[k] = (i == 0) ? 24'h7fffff : (i == 1) ? 24'h800000 : 24'($urandom);
			@(posedge clk);
			chan_valid <= 1'b1;
			chan_data <= {d[2], d[1], d[0]};
			@(posedge clk);
			chan_valid <= 1'b0;
			@(negedge clk);
			`CHK(cal_valid, 1'b1)
			for (k = 0; k < 3; k++) `CHK(cal_data[k*24 +: 24], exp_cal(d[k], t[k]))
		end
		// Factory source: read back follows the gain
		for (k = 0; k < 3; k++) wr(8'h21 + 8'(k), {1'b0, 11'h0, 12'($urandom)});
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			gain <= 2'(i);
			for (k = 0; k < 3; k++) chk_rd(8'h21 + 8'(k), {8'h21 + 8'(k), 12'h0, fact(i)});
		end
		// Amplitude settles on a steady band-pass level
		s[0] = {1'b0, 15'($urandom)};
		s[1] = 16'h8000;
		s[2] = 16'($urandom) | 16'h8000;
		@(posedge clk);
		{ac_sel, bp_valid} <= 2'b11;
		bp_data <= {s[2], s[1], s[0]};
		wait_cyc(4000);
		bp_valid <= 1'b0;
		wait_cyc(40);
		for (k = 0; k < 3; k++) begin
			a = 8'h31 + 8'(k);
			wr(a, 24'hffffff);
			chk_rd(a, {a, 8'h0, amp_exp(s[k])});
		end
		// Deselected: published value is frozen
		@(posedge clk);
		{ac_sel, bp_valid} <= 2'b01;
		bp_data <= '0;
		wait_cyc(40);
		bp_valid <= 1'b0;
		for (k = 0; k < 3; k++) chk_rd(8'h31 + 8'(k), {8'h31 + 8'(k), 8'h0, amp_exp(s[k])});
		print_verdict();
	end
endmodule : sgcl_regs_bench
`default_nettype wire
